// file: cal_bank.sv
/*
  register bank that implements the host access attributes: read only,
  write only, read/write, write one to clear, clear on read, latch low,
  latch high, self clearing and soft reset immunity, with reserved bits
  and a reserved register. assumes the host request port is synchronous
  to sys_clk and carries at most one read and one write per cycle.
*/
// Operation
// - read-only registers ignore every host write.
// - write-only registers always read back as zero.
// - read/write registers store the written value and return it.
// - writing one clears a write-one-to-clear bit; writing zero leaves it.
// - clear-on-read bits return their value, then clear because of that read.
// - latch-low bits hold a seen low level until the host reads them.
// - latch-high bits hold a seen high level until the host reads them.
// - soft reset leaves kept bits alone; other resets restore their defaults.
// - rst_n loads each register with its default, kept bits included.
`timescale 1ns/1ps
module cal_bank
    import cal_pkg::*;
(
    // clock and resets
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    input  wire logic                              soft_rst,
    // host request and answer
    input  wire cal_host_req_t                     host_req,
    output cal_rd_rsp_t                            rd_rsp,
    // hardware side, one word per register
    input  wire logic [REG_COUNT-1:0][DATA_W-1:0]  hw_in,
    // stored values towards the block's own logic
    output logic      [REG_COUNT-1:0][DATA_W-1:0]  reg_q,
    // one-cycle pulse after each accepted write, per register
    output logic      [REG_COUNT-1:0]              wr_strobe,
    // sticky flag: host wrote a reserved bit or register
    output logic                                   rsvd_write
);

    logic [REG_COUNT-1:0]  wr_hit;
    logic [REG_COUNT-1:0]  rd_hit;
    logic [DATA_W-1:0]     next_rd_data;
    logic                  next_rsvd_write;

    // address decode
    always_comb
    begin
        for (int r = 0; r < REG_COUNT; r++)
        begin
            wr_hit[r] = host_req.wr && (host_req.addr == ADDR_W'(r));
            rd_hit[r] = host_req.rd && (host_req.addr == ADDR_W'(r));
        end
    end

    // one cell per bit; reserved bits become cells that hold zero
    for (genvar r = 0; r < REG_COUNT; r++)
    begin : g_reg
        for (genvar b = 0; b < DATA_W; b++)
        begin : g_bit
            cal_bit_cell #(
                .ATTR (REG_USED[r][b] ? REG_ATTR[r] : CAL_RSVD),
                .INIT (REG_DEFAULT[r][b]),
                .KEEP (REG_KEEP[r][b])
            ) u_cell (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .soft_rst (soft_rst),
                .wr_hit   (wr_hit[r]),
                .wr_bit   (host_req.wdata[b]),
                .rd_hit   (rd_hit[r]),
                .hw_bit   (hw_in[r][b]),
                .q        (reg_q[r][b])
            );
        end
    end

    // read mux; old value is returned, side effects land on the same edge
    always_comb
    begin
        next_rd_data = ZERO_WORD;
        for (int r = 0; r < REG_COUNT; r++)
        begin
            if (rd_hit[r])
            begin
                case (REG_ATTR[r])
                    CAL_WO:   next_rd_data = ZERO_WORD;
                    CAL_RSVD: next_rd_data = ZERO_WORD;
                    default:  next_rd_data = reg_q[r] & REG_USED[r];
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_rsp.valid <= 1'b0;
            rd_rsp.data  <= ZERO_WORD;
        end
        else
        begin
            rd_rsp.valid <= host_req.rd;
            rd_rsp.data  <= next_rd_data;
        end
    end

    // write strobes for every register except the read-only and reserved ones
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_strobe <= '0;
        else
        begin
            for (int r = 0; r < REG_COUNT; r++)
            begin
                wr_strobe[r] <= wr_hit[r] && (REG_ATTR[r] != CAL_RO)
                                          && (REG_ATTR[r] != CAL_RSVD);
            end
        end
    end

    // reserved write detection
    always_comb
    begin
        next_rsvd_write = rsvd_write;
        for (int r = 0; r < REG_COUNT; r++)
        begin
            if (wr_hit[r] && (REG_ATTR[r] == CAL_RSVD))
                next_rsvd_write = 1'b1;
            if (wr_hit[r] && ((host_req.wdata & ~REG_USED[r]) != ZERO_WORD))
                next_rsvd_write = 1'b1;
        end
        if (host_req.wr && (host_req.addr >= ADDR_W'(REG_COUNT)))
            next_rsvd_write = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rsvd_write <= 1'b0;
        else if (soft_rst)
            rsvd_write <= 1'b0;
        else
            rsvd_write <= next_rsvd_write;
    end

endmodule

// file: cal_pkg.sv
/*
  shared constants, access attribute types and the register layout of the
  attribute bank. assumes a single clock domain and a host port that is
  synchronous to sys_clk.
*/
package cal_pkg;

    // bank shape
    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 4;
    localparam int REG_COUNT = 10;

    // access attributes of one bit
    typedef enum logic [3:0] {
        CAL_RSVD = 4'h0,
        CAL_RO   = 4'h1,
        CAL_WO   = 4'h2,
        CAL_RW   = 4'h3,
        CAL_W1C  = 4'h4,
        CAL_RC   = 4'h5,
        CAL_LATCH_LOW  = 4'h6,
        CAL_LATCH_HIGH = 4'h7,
        CAL_SELF_CLEAR = 4'h8
    } cal_attr_t;

    // register indices, which are also the host addresses
    localparam logic [ADDR_W-1:0] REG_STATUS     = 4'h0;
    localparam logic [ADDR_W-1:0] REG_COMMAND    = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CONFIG     = 4'h2;
    localparam logic [ADDR_W-1:0] REG_KEPT       = 4'h3;
    localparam logic [ADDR_W-1:0] REG_EVENT_W1C  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_EVENT_RC   = 4'h5;
    localparam logic [ADDR_W-1:0] REG_LATCH_LOW  = 4'h6;
    localparam logic [ADDR_W-1:0] REG_LATCH_HIGH = 4'h7;
    localparam logic [ADDR_W-1:0] REG_SELF_CLEAR = 4'h8;
    localparam logic [ADDR_W-1:0] REG_RESERVED   = 4'h9;

    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [DATA_W-1:0] ONES_WORD = 16'hFFFF;

    // attribute of each register, in index order
    localparam cal_attr_t REG_ATTR [REG_COUNT] = '{
        CAL_RO, CAL_WO, CAL_RW, CAL_RW, CAL_W1C,
        CAL_RC, CAL_LATCH_LOW, CAL_LATCH_HIGH, CAL_SELF_CLEAR, CAL_RSVD
    };

    // reset values
    localparam logic [DATA_W-1:0] REG_DEFAULT [REG_COUNT] = '{
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h0000
    };

    // implemented bits; a zero marks a reserved bit
    localparam logic [DATA_W-1:0] REG_USED [REG_COUNT] = '{
        16'hFFFF, 16'hFFFF, 16'h0FFF, 16'hFFFF, 16'h00FF,
        16'h00FF, 16'h00FF, 16'h00FF, 16'h000F, 16'h0000
    };

    // bits kept across soft reset
    localparam logic [DATA_W-1:0] REG_KEEP [REG_COUNT] = '{
        16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000
    };

    // host request and read answer
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cal_host_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } cal_rd_rsp_t;

endpackage

// file: cal_bit_cell.sv
/*
  one storage bit of the attribute bank, behaving as its access attribute
  says. assumes hits and the hardware input are synchronous to sys_clk.
*/
`timescale 1ns/1ps
module cal_bit_cell
    import cal_pkg::*;
#(
    parameter cal_attr_t ATTR = CAL_RW,
    parameter logic      INIT = 1'b0,
    parameter logic      KEEP = 1'b0
)
(
    // clock and resets
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic soft_rst,
    // host access to this bit
    input  wire logic wr_hit,
    input  wire logic wr_bit,
    input  wire logic rd_hit,
    // hardware side: level, event or action done
    input  wire logic hw_bit,
    // stored value
    output logic      q
);

    logic next_q;

    always_comb
    begin
        case (ATTR)
            CAL_RO:  next_q = hw_bit;
            CAL_WO:  next_q = wr_hit ? wr_bit : q;
            CAL_RW:  next_q = wr_hit ? wr_bit : q;
            CAL_W1C: next_q = hw_bit | (q & ~(wr_hit & wr_bit));
            CAL_RC:  next_q = hw_bit | (q & ~rd_hit);
            CAL_LATCH_LOW:  next_q = rd_hit ? hw_bit : (q & hw_bit);
            CAL_LATCH_HIGH: next_q = rd_hit ? hw_bit : (q | hw_bit);
            CAL_SELF_CLEAR: next_q = (wr_hit & wr_bit) | (q & ~hw_bit);
            default: next_q = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= INIT;
        else if (soft_rst && !KEEP)
            q <= INIT;
        else
            q <= next_q;
    end

endmodule

// file: cal_bank_props.sv
/* checker for the attribute bank, bound to cal_bank.
   sees only the bank's ports; one clock, async active-low reset. */
`timescale 1ns/1ps
module cal_bank_props
    import cal_pkg::*;
(
    // clock and resets
    input wire logic                             sys_clk,
    input wire logic                             rst_n,
    input wire logic                             soft_rst,
    // host port
    input wire cal_host_req_t                    host_req,
    input wire cal_rd_rsp_t                      rd_rsp,
    // hardware side and outputs
    input wire logic [REG_COUNT-1:0][DATA_W-1:0] hw_in,
    input wire logic [REG_COUNT-1:0][DATA_W-1:0] reg_q,
    input wire logic [REG_COUNT-1:0]             wr_strobe,
    input wire logic                             rsvd_write
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RO: assert property (!soft_rst |=> reg_q[0] == $past(hw_in[0]))
        else $error("read-only word left its input");
    AST_WO: assert property (host_req.rd && host_req.addr == REG_COMMAND |=> rd_rsp.data == '0)
        else $error("write-only word read nonzero");
    AST_RW: assert property (host_req.wr && host_req.addr == REG_CONFIG && !soft_rst
        |=> reg_q[2] == ($past(host_req.wdata) & 16'h0FFF))
        else $error("read/write word not stored");
    AST_W1C: assert property (host_req.wr && host_req.addr == REG_EVENT_W1C
        |=> (reg_q[4] & $past(host_req.wdata) & ~$past(hw_in[4])) == '0)
        else $error("written one did not clear");
    AST_RC: assert property (host_req.rd && host_req.addr == REG_EVENT_RC && !host_req.wr && !soft_rst
        |=> rd_rsp.data == $past(reg_q[5]) && reg_q[5] == ($past(hw_in[5]) & 16'h00FF))
        else $error("clear on read wrong");
    AST_LL: assert property (!(host_req.rd && host_req.addr == REG_LATCH_LOW) && !soft_rst
        |=> reg_q[6] == ($past(reg_q[6]) & $past(hw_in[6])))
        else $error("low latch lost");
    AST_LH: assert property (!(host_req.rd && host_req.addr == REG_LATCH_HIGH) && !soft_rst
        |=> reg_q[7] == (($past(reg_q[7]) | $past(hw_in[7])) & 16'h00FF))
        else $error("high latch lost");
    AST_RO_STROBE: assert property (host_req.wr && host_req.addr == REG_STATUS |=> wr_strobe == '0)
        else $error("read-only write raised a strobe");
    AST_RD_VALID: assert property (host_req.rd |=> rd_rsp.valid)
        else $error("read answer not flagged valid");
    AST_KEEP: assert property (soft_rst && !host_req.wr |=> $stable(reg_q[3]))
        else $error("kept word changed on soft reset");
    AST_DEF: assert property (soft_rst |=> reg_q[2] == '0 && reg_q[6] == 16'h00FF && !rsvd_write)
        else $error("soft reset defaults wrong");
    AST_SC: assert property (hw_in[8][0] && !host_req.wr && !soft_rst |=> !reg_q[8][0])
        else $error("self-clearing bit stuck");
endmodule
bind cal_bank cal_bank_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst),
    .host_req(host_req), .rd_rsp(rd_rsp), .hw_in(hw_in), .reg_q(reg_q),
    .wr_strobe(wr_strobe), .rsvd_write(rsvd_write));

// file: cal_host_model.sv
/* host model: one request per call, held for one taking edge.
   assumes the bank answers reads one cycle after the request. */
`timescale 1ns/1ps
module cal_host_model
    import cal_pkg::*;
(
    // clock
    input  wire logic        sys_clk,
    // host port
    output cal_host_req_t    host_req,
    input  wire cal_rd_rsp_t rd_rsp
);
    initial host_req = '0;
    task automatic op(input logic w, r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
        @(posedge sys_clk);
        #1 host_req = '{w, r, a, d};
        @(posedge sys_clk);
        #1 q = rd_rsp.data;
        host_req = '0;
    endtask
endmodule

// file: cal_bank_tb_top.sv
/* bench for the attribute bank: table of write/read pairs, then event,
   latch, reset and reserved cases. assumes cal_host_model drives the port. */
`timescale 1ns/1ps
module cal_bank_tb_top
    import cal_pkg::*;
;
    logic                             sys_clk = 0;
    logic                             rst_n = 0;
    logic                             soft_rst = 0;
    cal_host_req_t                    host_req;
    cal_rd_rsp_t                      rd_rsp;
    logic [REG_COUNT-1:0][DATA_W-1:0] hw_in = '0;
    logic [REG_COUNT-1:0][DATA_W-1:0] reg_q;
    logic [REG_COUNT-1:0]             wr_strobe;
    logic                             rsvd_write;
    logic [DATA_W-1:0]                q;
    int                               fail_count = 0;
    int                               samples_checked = 0;
    int                               cycles = 0;
    logic [35:0] rows [4] = '{{4'h0, 16'hFFFF, 16'h1234}, {4'h1, 16'hA5A5, 16'h0000},
                              {4'h2, 16'h0ABC, 16'h0ABC}, {4'h3, 16'h1357, 16'h1357}};
    cal_bank u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .soft_rst(soft_rst), .host_req(host_req),
        .rd_rsp(rd_rsp), .hw_in(hw_in), .reg_q(reg_q), .wr_strobe(wr_strobe), .rsvd_write(rsvd_write));
    cal_host_model u_host (.sys_clk(sys_clk), .host_req(host_req), .rd_rsp(rd_rsp));
    always #4 sys_clk = ~sys_clk;
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [DATA_W-1:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        u_host.op(1'b1, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        u_host.op(1'b0, 1'b1, a, 16'h0000, q);
        chk("read data", q, e);
        chk("read valid", {15'h0000, rd_rsp.valid}, 16'h0001);
    endtask
    // one-cycle change of a hardware input word
    task automatic hit(input int i, input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] old;
        old = hw_in[i];
        @(posedge sys_clk);
        #1 hw_in[i] = v;
        @(posedge sys_clk);
        #1 hw_in[i] = old;
    endtask
    initial
    begin
        hw_in[0] = 16'h1234;
        hw_in[6] = 16'h00FF;
        repeat (10) @(posedge sys_clk);
        #1 rst_n = 1;
        chk("latch low default", reg_q[6], 16'h00FF);
        foreach (rows[i])
        begin
            wr(rows[i][35:32], rows[i][31:16]);
            chk("write strobe", {6'h00, wr_strobe},
                (rows[i][35:32] == REG_STATUS) ? 16'h0000 : (16'h0001 << rows[i][35:32]));
            rd(rows[i][35:32], rows[i][15:0]);
        end
        hit(4, 16'h00FF);
        wr(REG_EVENT_W1C, 16'h000F);
        rd(REG_EVENT_W1C, 16'h00F0);
        hit(5, 16'h0003);
        rd(REG_EVENT_RC, 16'h0003);
        rd(REG_EVENT_RC, 16'h0000);
        hit(6, 16'h00FE);
        rd(REG_LATCH_LOW, 16'h00FE);
        rd(REG_LATCH_LOW, 16'h00FF);
        hit(7, 16'h0002);
        rd(REG_LATCH_HIGH, 16'h0002);
        rd(REG_LATCH_HIGH, 16'h0000);
        wr(REG_SELF_CLEAR, 16'h0005);
        rd(REG_SELF_CLEAR, 16'h0005);
        hit(8, 16'h0005);
        rd(REG_SELF_CLEAR, 16'h0000);
        chk("reserved flag", {15'h0000, rsvd_write}, 16'h0000);
        wr(REG_RESERVED, 16'h0001);
        chk("write strobe", {6'h00, wr_strobe}, 16'h0000);
        chk("reserved flag", {15'h0000, rsvd_write}, 16'h0001);
        @(posedge sys_clk);
        #1 soft_rst = 1;
        @(posedge sys_clk);
        #1 soft_rst = 0;
        chk("reserved flag", {15'h0000, rsvd_write}, 16'h0000);
        rd(REG_KEPT, 16'h1357);
        rd(REG_CONFIG, 16'h0000);
        wr(REG_CONFIG, 16'hF001);
        rd(REG_CONFIG, 16'h0001);
        chk("reserved flag", {15'h0000, rsvd_write}, 16'h0001);
        @(posedge sys_clk);
        #1 rst_n = 0;
        @(posedge sys_clk);
        #1 rst_n = 1;
        chk("reserved flag", {15'h0000, rsvd_write}, 16'h0000);
        rd(REG_KEPT, 16'h0000);
        wr(4'hC, 16'h0000);
        chk("reserved flag", {15'h0000, rsvd_write}, 16'h0001);
        rd(4'hC, 16'h0000);
        close_out();
    end
endmodule
